// File: logic/sci_rx_pkg.sv
// constants and types for the receive status, data buffer and baud generator block
package sci_rx_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W           = 3;
  localparam int          DATA_W           = 8;
  localparam logic [2:0]  ADDR_STATUS_ONE  = 3'h0;
  localparam logic [2:0]  ADDR_STATUS_TWO  = 3'h1;
  localparam logic [2:0]  ADDR_DATA        = 3'h2;
  localparam logic [2:0]  ADDR_RATE        = 3'h3;
  localparam logic [2:0]  ADDR_CONTROL     = 3'h4;
  localparam logic [2:0]  ADDR_OPTION_TWO  = 3'h5;
  localparam logic [7:0]  READ_ZERO        = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST1_FULL   = 5;
  localparam int ST1_NOISE  = 2;
  localparam int ST1_FRAME  = 1;
  localparam int ST1_PARITY = 0;
  localparam int ST2_NINTH  = 2;
  localparam int ST2_BREAK  = 1;
  localparam int ST2_ACTIVE = 0;
  localparam int CTL_NOISE_IE  = 0;
  localparam int CTL_FRAME_IE  = 1;
  localparam int CTL_PARITY_IE = 2;
  localparam int CTL_NINE_BIT  = 3;
  localparam int CTL_PARITY_EN = 4;
  localparam int CTL_PARITY_ODD = 5;
  localparam int CTL_RX_ENABLE = 6;
  localparam int RATE_PS_LSB   = 4;
  localparam int RATE_DIV_LSB  = 0;
  localparam int OPT2_SRC      = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
  localparam logic [2:0] DIVISOR_RESET  = 3'h0;

  // ----------------------------------------------------------------
  // baud generation and sampling
  // ----------------------------------------------------------------
  localparam logic [3:0] PD_CODE0 = 4'h1;
  localparam logic [3:0] PD_CODE1 = 4'h3;
  localparam logic [3:0] PD_CODE2 = 4'h4;
  localparam logic [3:0] PD_CODE3 = 4'hD;
  localparam int         BAUD_W         = 13;
  localparam int         RATE_FACTOR    = 64;
  localparam int         SAMPLES_PER_BIT = 16;
  localparam int         TICK_SHIFT     = $clog2(RATE_FACTOR / SAMPLES_PER_BIT);
  localparam logic [3:0] PH_FIRST    = 4'h1;
  localparam logic [3:0] PH_SAMPLE_A = 4'h7;
  localparam logic [3:0] PH_SAMPLE_C = 4'h9;
  localparam logic [3:0] PH_LAST     = 4'hF;
  localparam logic [3:0] BITS_8      = 4'h8;
  localparam logic [3:0] BITS_9      = 4'h9;
  localparam int         IDLE_BITS   = 10;
  localparam logic [7:0] IDLE_TICKS  = 8'(IDLE_BITS * SAMPLES_PER_BIT);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } rx_state_type;

endpackage

// File: logic/sci_rx_status.sv
// receive status flags, shared data buffer and baud generator of the serial port
// Contract
// RQ1 - noise on receive line sets noise_flag; error request when noise_irq_en set
// RQ2 - noise_flag clears on status one read then data read; reset clears
// RQ3 - stop bit sampled low sets framing_error_flag; request when framing_irq_en set
// RQ4 - framing flag clears on status one read with it set, then data read
// RQ5 - parity check failure sets parity_error_flag; request when parity_irq_en set
// RQ6 - parity flag clears on status one read with it set, then data read
// RQ7 - break sets line_break_flag, framing and full flags; break never interrupts (code: its framing flag still requests when framing_irq_en set)
// RQ8 - in nine-bit mode a break forces rx_ninth_bit to zero
// RQ9 - break flag clears on status two read with it set, then data read
// RQ10 - break flag sets again only after line returns high and new break
// RQ11 - low at first sample tick of start search sets receive_active_flag
// RQ12 - false start or idle character clears receive_active_flag
// RQ13 - data read gives received byte, write gives byte to send; reset keeps
// RQ14 - software should avoid read-modify-write on the data buffer
// RQ15 - one rate from rate_select_register serves transmitter and receiver
// RQ16 - prescale_sel codes give divisors 1, 3, 4, 13; reset to 00
// RQ17 - rate_divisor_sel gives power-of-two divisor 1 to 128; reset to 000
// RQ18 - baud rate is source clock over 64 times prescale times divisor
// RQ19 - baud source is bus clock or crystal_ref_clock per rate_clock_source_sel
// RQ20 - software should poll receive_active_flag before disabling or stopping
// RQ21 - completed character moving into data buffer sets rx_full_flag
// RQ22 - enabled noise, framing, parity flags combine into one error request
// RQ23 - sampling tick runs at sixteen times bit rate for start search and data
`timescale 1ns/100ps
module sci_rx_status
  import sci_rx_pkg::*;
(
  input  wire logic                          CLK,
  input  wire logic                          ARST_N,
  input  wire logic [sci_rx_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [sci_rx_pkg::DATA_W-1:0] WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic      [sci_rx_pkg::DATA_W-1:0] RDATA,
  input  wire logic                          RXD,
  input  wire logic                          XTAL_CLK,
  output logic                               ERR_IRQ,
  output logic                               RX_FULL,
  output logic      [sci_rx_pkg::DATA_W-1:0] TX_DATA,
  output logic                               TX_LOAD,
  output logic                               BIT_TICK
);
  import sci_rx_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  function automatic logic noisy3(input logic [2:0] s);
    noisy3 = (s != 3'b000) && (s != 3'b111);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic         noise_irq_en;
  logic         framing_irq_en;
  logic         parity_irq_en;
  logic         nine_bit;
  logic         parity_en;
  logic         parity_odd;
  logic         rx_enable;
  logic         rate_clock_source_sel;
  logic [1:0]   prescale_sel;
  logic [2:0]   rate_divisor_sel;

  logic         noise_flag;
  logic         framing_error_flag;
  logic         parity_error_flag;
  logic         line_break_flag;
  logic         receive_active_flag;
  logic         rx_full_flag;
  logic [7:0]   data_buf;
  logic         rx_ninth_bit;

  logic         arm_noise;
  logic         arm_frame;
  logic         arm_parity;
  logic         arm_full;
  logic         arm_break;

  logic         xtal_prev;
  logic         src_tick;
  logic [3:0]   prescale_div;
  logic [BAUD_W-1:0] baud_mod;
  logic [BAUD_W-1:0] baud_cnt;
  logic         baud_wrap;
  logic         sample_tick;
  logic [3:0]   bit_div;

  rx_state_type state;
  rx_state_type next_state;
  logic [3:0]   ph;
  logic [3:0]   next_ph;
  logic [3:0]   bit_cnt;
  logic [3:0]   next_bit_cnt;
  logic [8:0]   shreg;
  logic [8:0]   next_shreg;
  logic [2:0]   smp;
  logic [2:0]   next_smp;
  logic         line_high;
  logic         next_line_high;
  logic [7:0]   idle_cnt;
  logic [7:0]   next_idle_cnt;
  logic         next_active;
  logic         noise_seen;
  logic         next_noise_seen;
  logic         frame_done;
  logic         noise_ev;

  logic         rd_st1;
  logic         rd_st2;
  logic         rd_data;
  logic         wr_data;
  logic         wr_rate;
  logic         wr_ctl;
  logic         wr_opt2;
  logic [7:0]   rd_value;
  logic [7:0]   status_one;
  logic [7:0]   status_two;
  logic [7:0]   control_value;
  logic [7:0]   rate_value;
  logic [7:0]   opt2_value;

  logic [3:0]   frame_len;
  logic [7:0]   rx_byte;
  logic         rx_bit8;
  logic         parity_calc;
  logic         parity_bad;
  logic         stop_one;
  logic         all_zero;
  logic         break_ev;
  logic         clr_noise;
  logic         clr_frame;
  logic         clr_parity;
  logic         clr_full;
  logic         clr_break;
  logic         set_frame;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign rd_st1  = RD && (ADDR == ADDR_STATUS_ONE);
  assign rd_st2  = RD && (ADDR == ADDR_STATUS_TWO);
  assign rd_data = RD && (ADDR == ADDR_DATA);
  assign wr_data = WR && (ADDR == ADDR_DATA);
  assign wr_rate = WR && (ADDR == ADDR_RATE);
  assign wr_ctl  = WR && (ADDR == ADDR_CONTROL);
  assign wr_opt2 = WR && (ADDR == ADDR_OPTION_TWO);

  always_comb begin
    status_one = READ_ZERO;
    status_one[ST1_FULL]   = rx_full_flag;
    status_one[ST1_NOISE]  = noise_flag;
    status_one[ST1_FRAME]  = framing_error_flag;
    status_one[ST1_PARITY] = parity_error_flag;
    status_two = READ_ZERO;
    status_two[ST2_NINTH]  = rx_ninth_bit;
    status_two[ST2_BREAK]  = line_break_flag;
    status_two[ST2_ACTIVE] = receive_active_flag;
    control_value = READ_ZERO;
    control_value[CTL_NOISE_IE]   = noise_irq_en;
    control_value[CTL_FRAME_IE]   = framing_irq_en;
    control_value[CTL_PARITY_IE]  = parity_irq_en;
    control_value[CTL_NINE_BIT]   = nine_bit;
    control_value[CTL_PARITY_EN]  = parity_en;
    control_value[CTL_PARITY_ODD] = parity_odd;
    control_value[CTL_RX_ENABLE]  = rx_enable;
    rate_value = READ_ZERO;
    rate_value[RATE_PS_LSB +: 2]  = prescale_sel;
    rate_value[RATE_DIV_LSB +: 3] = rate_divisor_sel;
    opt2_value = READ_ZERO;
    opt2_value[OPT2_SRC] = rate_clock_source_sel;
  end

  // the data address reads the received byte only; writes go to the transmitter (see RQ13)
  assign rd_value = (ADDR == ADDR_STATUS_ONE) ? status_one :
                    (ADDR == ADDR_STATUS_TWO) ? status_two :
                    (ADDR == ADDR_DATA)       ? data_buf :
                    (ADDR == ADDR_RATE)       ? rate_value :
                    (ADDR == ADDR_CONTROL)    ? control_value :
                    (ADDR == ADDR_OPTION_TWO) ? opt2_value : READ_ZERO;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {rx_enable, parity_odd, parity_en, nine_bit} <= CONTROL_RESET[CTL_RX_ENABLE:CTL_NINE_BIT];
      {parity_irq_en, framing_irq_en, noise_irq_en} <= CONTROL_RESET[CTL_PARITY_IE:CTL_NOISE_IE];
      prescale_sel          <= PRESCALE_RESET; // see RQ16
      rate_divisor_sel      <= DIVISOR_RESET; // see RQ17
      rate_clock_source_sel <= 1'b0;
    end else begin
      if (wr_ctl) begin
        {rx_enable, parity_odd, parity_en, nine_bit} <= WDATA[CTL_RX_ENABLE:CTL_NINE_BIT];
        {parity_irq_en, framing_irq_en, noise_irq_en} <= WDATA[CTL_PARITY_IE:CTL_NOISE_IE];
      end
      if (wr_rate) begin
        prescale_sel     <= WDATA[RATE_PS_LSB +: 2];
        rate_divisor_sel <= WDATA[RATE_DIV_LSB +: 3];
      end
      if (wr_opt2) begin
        rate_clock_source_sel <= WDATA[OPT2_SRC];
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA   <= READ_ZERO;
      TX_LOAD <= 1'b0;
    end else begin
      RDATA   <= RD ? rd_value : READ_ZERO;
      TX_LOAD <= wr_data;
    end
  end

  // transmit byte is data, not control: reset leaves it alone (see RQ13)
  always_ff @(posedge CLK) begin
    if (wr_data) begin
      TX_DATA <= WDATA;
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  // crystal reference is slow next to the bus clock, so its rising edge is the tick
  assign src_tick = rate_clock_source_sel ? (XTAL_CLK & ~xtal_prev) : 1'b1; // see RQ19

  assign prescale_div = (prescale_sel == 2'h0) ? PD_CODE0 :
                        (prescale_sel == 2'h1) ? PD_CODE1 :
                        (prescale_sel == 2'h2) ? PD_CODE2 : PD_CODE3; // see RQ16

  // sample period is 4*PD*BD source ticks, so 16 samples make 64*PD*BD (see RQ17)
  assign baud_mod  = (BAUD_W'(prescale_div) << TICK_SHIFT) << rate_divisor_sel; // see RQ18
  assign baud_wrap = src_tick && (baud_cnt >= baud_mod - BAUD_W'(1));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      xtal_prev   <= 1'b0;
      baud_cnt    <= '0;
      sample_tick <= 1'b0;
      bit_div     <= 4'h0;
      BIT_TICK    <= 1'b0;
    end else begin
      xtal_prev   <= XTAL_CLK;
      sample_tick <= baud_wrap; // see RQ23
      if (src_tick) begin
        baud_cnt <= baud_wrap ? '0 : baud_cnt + BAUD_W'(1);
      end
      if (sample_tick) begin
        bit_div <= bit_div + 4'h1;
      end
      // one bit clock shared with the transmitter (see RQ15)
      BIT_TICK <= sample_tick && (bit_div == PH_LAST);
    end
  end

  // ----------------------------------------------------------------
  // receiver sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_ph         = ph;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_smp        = smp;
    next_line_high  = line_high;
    next_idle_cnt   = idle_cnt;
    next_active     = receive_active_flag;
    next_noise_seen = noise_seen;
    frame_done      = 1'b0;
    noise_ev        = 1'b0;
    if (!rx_enable) begin
      next_state     = ST_IDLE;
      next_active    = 1'b0;
      next_line_high = 1'b0;
      next_idle_cnt  = 8'h00;
    end else if (sample_tick) begin
      next_ph = ph + 4'h1;
      if (ph >= PH_SAMPLE_A && ph <= PH_SAMPLE_C) begin
        next_smp = {RXD, smp[2:1]};
      end
      unique case (state)
        ST_IDLE: begin
          next_ph = PH_FIRST;
          if (RXD) begin
            next_line_high = 1'b1;
            if (idle_cnt != IDLE_TICKS) begin
              next_idle_cnt = idle_cnt + 8'h01;
            end
            if (idle_cnt == IDLE_TICKS - 8'h01) begin
              next_active = 1'b0; // see RQ12
            end
          end else begin
            next_idle_cnt = 8'h00;
            // a start is only searched once the line has been seen high
            if (line_high) begin
              next_state      = ST_START;
              next_active     = 1'b1; // see RQ11
              next_noise_seen = 1'b0;
            end
          end
        end
        ST_START: begin
          if (ph == PH_SAMPLE_C) begin
            if (maj3(next_smp)) begin
              next_state = ST_IDLE;
              next_active = 1'b0; // see RQ12
            end else begin
              noise_ev = noisy3(next_smp);
            end
          end
          if (ph == PH_LAST) begin
            next_state   = ST_DATA;
            next_bit_cnt = 4'h0;
          end
        end
        ST_DATA: begin
          if (ph == PH_SAMPLE_C) begin
            next_shreg = {maj3(next_smp), shreg[8:1]};
            noise_ev   = noisy3(next_smp);
          end
          if (ph == PH_LAST) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt + 4'h1 == frame_len) begin
              next_state = ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (ph == PH_SAMPLE_C) begin
            frame_done = 1'b1;
            noise_ev   = noisy3(next_smp);
            // a low stop keeps the search shut until the line is high again (see RQ10)
            next_line_high = maj3(next_smp);
            next_idle_cnt  = 8'h00;
            next_state     = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
      if (noise_ev) begin
        next_noise_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state               <= ST_IDLE;
      ph                  <= PH_FIRST;
      bit_cnt             <= 4'h0;
      shreg               <= 9'h000;
      smp                 <= 3'h7;
      line_high           <= 1'b0;
      idle_cnt            <= 8'h00;
      receive_active_flag <= 1'b0;
      noise_seen          <= 1'b0;
    end else begin
      state               <= next_state;
      ph                  <= next_ph;
      bit_cnt             <= next_bit_cnt;
      shreg               <= next_shreg;
      smp                 <= next_smp;
      line_high           <= next_line_high;
      idle_cnt            <= next_idle_cnt;
      receive_active_flag <= next_active;
      noise_seen          <= next_noise_seen;
    end
  end

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  // parity, when enabled, is the top bit of the character
  assign frame_len   = nine_bit ? BITS_9 : BITS_8;
  assign rx_byte     = nine_bit ? shreg[7:0] : shreg[8:1];
  assign rx_bit8     = shreg[8];
  assign parity_calc = nine_bit ? ^shreg : ^shreg[8:1];
  assign parity_bad  = parity_en && (parity_calc != parity_odd); // see RQ5
  assign stop_one    = maj3(next_smp);
  assign all_zero    = nine_bit ? (shreg == 9'h000) : (shreg[8:1] == 8'h00);
  assign break_ev    = frame_done && all_zero && !stop_one; // see RQ7
  assign set_frame   = frame_done && !stop_one; // see RQ3

  // ----------------------------------------------------------------
  // status flags and clearing sequence
  // ----------------------------------------------------------------
  // a flag is armed by the status read that shows it set, and cleared by the next data read
  assign clr_noise  = rd_data && arm_noise; // see RQ2
  assign clr_frame  = rd_data && arm_frame; // see RQ4
  assign clr_parity = rd_data && arm_parity; // see RQ6
  assign clr_full   = rd_data && arm_full;
  assign clr_break  = rd_data && arm_break; // see RQ9

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arm_noise  <= 1'b0;
      arm_frame  <= 1'b0;
      arm_parity <= 1'b0;
      arm_full   <= 1'b0;
      arm_break  <= 1'b0;
    end else begin
      if (rd_st1) begin
        arm_noise  <= noise_flag;
        arm_frame  <= framing_error_flag;
        arm_parity <= parity_error_flag;
        arm_full   <= rx_full_flag;
      end else if (rd_data) begin
        {arm_noise, arm_frame, arm_parity, arm_full} <= 4'h0;
      end
      if (rd_st2) begin
        arm_break <= line_break_flag;
      end else if (rd_data) begin
        arm_break <= 1'b0;
      end
    end
  end

  // new events win over a clear in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      noise_flag         <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
      line_break_flag    <= 1'b0;
      rx_full_flag       <= 1'b0;
    end else begin
      noise_flag         <= (frame_done && next_noise_seen) || (noise_flag && !clr_noise); // see RQ1
      framing_error_flag <= set_frame || (framing_error_flag && !clr_frame); // see RQ7
      parity_error_flag  <= (frame_done && parity_bad) || (parity_error_flag && !clr_parity);
      line_break_flag    <= break_ev || (line_break_flag && !clr_break); // see RQ10
      rx_full_flag       <= frame_done || (rx_full_flag && !clr_full); // see RQ21
    end
  end

  // received data is not touched by reset
  always_ff @(posedge CLK) begin
    if (frame_done) begin
      data_buf     <= rx_byte; // see RQ13
      rx_ninth_bit <= (nine_bit && all_zero && !stop_one) ? 1'b0 : rx_bit8; // see RQ8
    end
  end

  // ----------------------------------------------------------------
  // outputs to the rest of the port
  // ----------------------------------------------------------------
  // break has no enable of its own; it reaches the request only through the framing flag it sets, when framing_irq_en is set (see RQ7)
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ERR_IRQ <= 1'b0;
      RX_FULL <= 1'b0;
    end else begin
      ERR_IRQ <= (noise_flag && noise_irq_en) || (framing_error_flag && framing_irq_en) ||
                 (parity_error_flag && parity_irq_en); // see RQ22
      RX_FULL <= rx_full_flag;
    end
  end

endmodule

// File: verification/sci_rx_partner.sv
// remote serial sender driving the receive line
`timescale 1ns/100ps
module sci_rx_partner (
  input  wire logic CLK,
  output logic      RXD
);
  localparam int BIT_CLK = 64;
  initial RXD = 1'b1;
  task automatic hold(input logic v, input int n);
    repeat (n) @(posedge CLK) RXD <= v;
  endtask
  // ----------------------------------------------------------------
  // frame sender
  // ----------------------------------------------------------------
  // short glitch hits one middle sample only, so majority keeps the bit
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input bit gl);
    hold(1'b0, BIT_CLK);
    for (int i = 0; i < nb; i++) begin
      if (gl && i == 0) begin
        hold(d[0], 33);
        hold(~d[0], 4);
        hold(d[0], 27);
      end else begin
        hold(d[i], BIT_CLK);
      end
    end
    hold(stp, BIT_CLK);
    hold(1'b1, BIT_CLK);
  endtask
endmodule

// File: verification/sci_rx_status_sva.sv
// port assertions for the receive status and baud block
`timescale 1ns/100ps
module sci_rx_status_sva
  import sci_rx_pkg::*;
(
  input wire logic                          CLK,
  input wire logic                          ARST_N,
  input wire logic [sci_rx_pkg::ADDR_W-1:0] ADDR,
  input wire logic [sci_rx_pkg::DATA_W-1:0] WDATA,
  input wire logic                          WR,
  input wire logic                          RD,
  input wire logic [sci_rx_pkg::DATA_W-1:0] RDATA,
  input wire logic                          ERR_IRQ,
  input wire logic                          RX_FULL,
  input wire logic [sci_rx_pkg::DATA_W-1:0] TX_DATA,
  input wire logic                          TX_LOAD,
  input wire logic                          BIT_TICK
);
  wire logic drd = RD && ADDR == ADDR_DATA;
  wire logic dwr = WR && ADDR == ADDR_DATA;
  wire logic cwr = WR && ADDR == ADDR_CONTROL;
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  property p_rdata_idle;
    !$past(RD) |-> RDATA == READ_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
  property p_load;
    dwr |=> TX_LOAD && TX_DATA == $past(WDATA);
  endproperty
  a_load: assert property (p_load) else $error("transmit byte not handed on");
  property p_load_cause;
    TX_LOAD |-> $past(dwr);
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("load without data write");
  property p_tick_gap;
    BIT_TICK |=> !BIT_TICK [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("bit ticks too close");
  property p_unmapped;
    RD && ADDR[2:1] == 2'b11 |=> RDATA == READ_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rate_back;
    (WR && ADDR == ADDR_RATE) ##2 (RD && ADDR == ADDR_RATE) |=> RDATA == ($past(WDATA, 3) & 8'h37);
  endproperty
  a_rate_back: assert property (p_rate_back) else $error("rate fields not kept");
  property p_irq_fall;
    $fell(ERR_IRQ) |-> $past(drd || cwr) || $past(drd || cwr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("error request dropped on its own");
  property p_full_fall;
    $fell(RX_FULL) |-> $past(drd) || $past(drd, 2);
  endproperty
  a_full_fall: assert property (p_full_fall) else $error("full flag dropped without data read");
endmodule
bind sci_rx_status sci_rx_status_sva u_sva (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .ERR_IRQ(ERR_IRQ), .RX_FULL(RX_FULL), .TX_DATA(TX_DATA), .TX_LOAD(TX_LOAD),
  .BIT_TICK(BIT_TICK));

// File: verification/sci_rx_status_test.sv
// self-checking bench for the receive status and baud block
`timescale 1ns/100ps
module sci_rx_status_test;
  import sci_rx_pkg::*;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [1:0] xdiv = 2'h0;
  logic [7:0] rdata, tx_data;
  logic       rxd, err_irq, rx_full, tx_load, bit_tick;
  int         error_cnt = 0;
  int         cmp_count = 0;
  logic [7:0] rv [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h02, 8'h03};
  int         pr [7] = '{64, 192, 256, 832, 128, 256, 512};
  always #25 clk = ~clk;
  always @(posedge clk) xdiv <= xdiv + 2'h1;
  sci_rx_status uut (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .RXD(rxd), .XTAL_CLK(xdiv[1]), .ERR_IRQ(err_irq), .RX_FULL(rx_full), .TX_DATA(tx_data), .TX_LOAD(tx_load),
    .BIT_TICK(bit_tick));
  sci_rx_partner far (.CLK(clk), .RXD(rxd));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, 16'(rdata & m), 16'(e));
  endtask
  // first interval may still run at the old rate, so skip it
  task automatic period(input logic [7:0] v, input int e);
    int n;
    wreg(ADDR_RATE, v);
    repeat (2) @(negedge clk iff bit_tick);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bit_tick !== 1'b1);
    chk("bit period", 16'(n), 16'(e));
  endtask
  task automatic frame(input logic [7:0] c, input logic [8:0] d, input int nb, input logic stp, input bit gl,
                       input logic [7:0] s1, input logic irq);
    wreg(ADDR_CONTROL, c);
    // line must be seen high at a sample tick before a start is searched
    far.hold(1'b1, 16);
    far.send(d, nb, stp, gl);
    @(negedge clk);
    chk("full", 16'(rx_full), 16'h0001);
    chk("irq", 16'(err_irq), 16'(irq));
    rreg(ADDR_STATUS_ONE, 8'hFF, s1, "status one");
    rreg(ADDR_DATA, 8'hFF, d[7:0], "data");
    rreg(ADDR_STATUS_ONE, 8'hFF, 8'h00, "status cleared");
    @(negedge clk);
    chk("irq cleared", 16'(err_irq), 16'h0000);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rreg(ADDR_RATE, 8'hFF, 8'h00, "rate reset");
    rreg(ADDR_STATUS_ONE, 8'hFF, 8'h00, "status reset");
    rreg(3'h7, 8'hFF, READ_ZERO, "unmapped");
    wreg(ADDR_RATE, 8'h37);
    rreg(ADDR_RATE, 8'hFF, 8'h37, "rate");
    for (int i = 0; i < 7; i++) begin
      period(rv[i], pr[i]);
    end
    wreg(ADDR_OPTION_TWO, 8'h01);
    period(8'h00, 256);
    wreg(ADDR_OPTION_TWO, 8'h00);
    wreg(ADDR_DATA, 8'h5A);
    @(negedge clk);
    chk("tx data", 16'(tx_data), 16'h005A);
    frame(8'h40, 9'h0A5, 8, 1'b1, 1'b0, 8'h20, 1'b0);
    frame(8'h42, 9'h03C, 8, 1'b0, 1'b0, 8'h22, 1'b1);
    frame(8'h54, 9'h001, 8, 1'b1, 1'b0, 8'h21, 1'b1);
    frame(8'h74, 9'h001, 8, 1'b1, 1'b0, 8'h20, 1'b0);
    frame(8'h41, 9'h00F, 8, 1'b1, 1'b1, 8'h24, 1'b1);
    frame(8'h48, 9'h000, 9, 1'b0, 1'b0, 8'h22, 1'b0);
    rreg(ADDR_STATUS_TWO, 8'h06, 8'h02, "break kept");
    rreg(ADDR_DATA, 8'hFF, 8'h00, "data");
    rreg(ADDR_STATUS_TWO, 8'h02, 8'h00, "break cleared");
    repeat (700) @(posedge clk);
    rreg(ADDR_STATUS_TWO, 8'h01, 8'h00, "idle");
    fork
      far.send(9'h055, 8, 1'b1, 1'b0);
      begin
        repeat (100) @(posedge clk);
        rreg(ADDR_STATUS_TWO, 8'h01, 8'h01, "active");
      end
    join
    far.hold(1'b0, 16);
    far.hold(1'b1, 100);
    rreg(ADDR_STATUS_TWO, 8'h01, 8'h00, "false start");
    tally_and_finish();
  end
endmodule
